// ===== hw/slw_ctrl.sv
`timescale 1ns/10ps
module slw_ctrl
  import slw_pkg::*;
(
  input  wire logic                 mclk_in,           // 125 MHz logic clock
  input  wire logic                 nrst_in,           // async reset, active low
  input  wire logic                 ce_in,             // clock enable, freezes state except the power-off clear
  input  wire logic                 wake_in,           // internal wake level
  input  wire logic                 host_reset_in,     // host reset pin, async
  input  wire logic                 woke_by_reset_in,  // wake source was host reset
  input  wire logic                 bat_por_ok_in,     // battery above por, async
  input  wire logic                 vlog_por_ok_in,    // logic supply above por, async
  input  wire logic                 gnd_lost_in,       // ground loss detect, async
  input  wire logic                 fail_mode_in,      // fail-mode pin, async
  input  wire logic [NUM_DIR-1:0]   direct_in,         // direct channel inputs, async
  input  wire logic                 spi_err_in,        // spi error pulse incl watchdog
  input  wire logic                 spi_wd_timeout_in, // spi watchdog expired pulse
  input  wire logic                 cfg_we_in,         // configuration write strobe
  input  wire logic [2:0]           cfg_sel_in,        // configuration word select
  input  wire logic [CFG_W-1:0]     cfg_wdata_in,      // configuration write data
  input  wire logic                 rd_req_in,         // register read request
  input  wire logic [NUM_FAULT-1:0] fault_set_in,      // fault events from detectors
  input  wire logic                 fault_clr_in,      // clear fault flags
  input  wire logic                 pwm_clk_fail_in,   // pwm clock failure level
  input  wire logic                 clk_pin_in,        // shared clock pin input
  output logic                      clk_pin_out,       // shared clock pin output
  output logic                      clk_pin_oe_out,    // shared clock pin drive enable
  output logic [NUM_CH-1:0]         power_channels,    // power channel gates
  output logic                      external_switch_output,    // external switch drive
  output logic                      external_switch_oe_out,    // external switch enable
  output logic [NUM_FAULT-1:0]      fault_out,         // fault flags
  output logic [CFG_W-1:0]          rd_data_out,       // read data
  output logic                      rd_valid_out,      // read data valid
  output logic                      sense_sync_output, // current sense sync pulse
  output logic [1:0]                mode_out,          // present mode
  output logic                      wd_expire_out,     // watchdog timeout request
  output logic                      clk_pin_sample_out // synchronised clock pin level
);
  // synchronised asynchronous levels
  logic [NUM_DIR+5:0] async_bus;
  logic [NUM_DIR+5:0] sync_bus;
  logic               bat_ok;
  logic               vlog_ok;
  logic               gnd_lost;
  logic               fail_pin;
  logic               host_rst;
  logic               clk_pin_s;
  logic [NUM_DIR-1:0] dir_s;

  assign async_bus = {clk_pin_in, direct_in, host_reset_in, fail_mode_in,
                      gnd_lost_in, vlog_por_ok_in, bat_por_ok_in};

  slw_sync #(.W(NUM_DIR + 6)) u_sync (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .ce_in   (ce_in),
    .d_in    (async_bus),
    .q_out   (sync_bus)
  );

  assign bat_ok    = sync_bus[0];
  assign vlog_ok   = sync_bus[1];
  assign gnd_lost  = sync_bus[2];
  assign fail_pin  = sync_bus[3];
  assign host_rst  = sync_bus[4];
  assign dir_s     = sync_bus[NUM_DIR+4:5];
  assign clk_pin_s = sync_bus[NUM_DIR+5];

  // supply situation decode
  logic power_off;
  logic bat_loss_only;
  logic vlog_loss_only;
  assign power_off      = !bat_ok && !vlog_ok;
  assign bat_loss_only  = !bat_ok && vlog_ok;
  assign vlog_loss_only = bat_ok && !vlog_ok;

  // clear asserted on the clock by power off, released on the clock
  logic clr_n_meta_r;
  logic clr_n_r;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clr_n_meta_r <= 1'b0;
      clr_n_r      <= 1'b0;
    end else if (power_off) begin
      clr_n_meta_r <= 1'b0;
      clr_n_r      <= 1'b0;
    end else if (ce_in) begin
      clr_n_meta_r <= 1'b1;
      clr_n_r      <= clr_n_meta_r;
    end
  end

  logic regs_nrst;
  assign regs_nrst = nrst_in && clr_n_r;

  // configuration words: 0..4 channel duty, 5 external switch, 6 and 7 pwm enable
  logic [CFG_W-1:0] duty_r [NUM_CH];
  logic             ext_sw_r;
  logic [NUM_CH-1:0] ch_en_r;
  always_ff @(posedge mclk_in or negedge regs_nrst) begin
    if (!regs_nrst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_r[i] <= CFG_RST;
      end
      ext_sw_r <= 1'b0;
      ch_en_r  <= CH_OFF;
    end else if (ce_in && cfg_we_in && vlog_ok) begin
      if (cfg_sel_in < 3'(NUM_CH)) begin
        duty_r[cfg_sel_in] <= cfg_wdata_in;
      end else if (cfg_sel_in == 3'(NUM_CH)) begin
        ext_sw_r <= cfg_wdata_in[0];
      end else begin
        ch_en_r <= cfg_wdata_in[NUM_CH-1:0];
      end
    end
  end

  // fault flags, a new event wins over a clear
  logic [NUM_FAULT-1:0] fault_r;
  logic [NUM_FAULT-1:0] fault_nxt;
  logic [NUM_FAULT-1:0] fault_evt;
  assign fault_evt = fault_set_in | (NUM_FAULT'(pwm_clk_fail_in) << FLT_CLK);
  assign fault_nxt = (fault_clr_in ? FAULT_RST : fault_r) | fault_evt;
  always_ff @(posedge mclk_in or negedge regs_nrst) begin
    if (!regs_nrst) begin
      fault_r <= FAULT_RST;
    end else if (ce_in) begin
      fault_r <= fault_nxt;
    end
  end
  assign fault_out = fault_r;

  // mode decode
  slw_mode_t mode_r;
  slw_mode_t mode_nxt;
  logic      fail_req;
  assign fail_req = fail_pin || spi_err_in || spi_wd_timeout_in || vlog_loss_only;

  // wake level selects sleep or operation
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      SLW_OFF:    mode_nxt = power_off ? SLW_OFF : (wake_in ? SLW_NORMAL : SLW_SLEEP);
      SLW_SLEEP:  mode_nxt = wake_in ? (fail_req ? SLW_FAIL : SLW_NORMAL) : SLW_SLEEP;
      SLW_NORMAL: mode_nxt = !wake_in ? SLW_SLEEP : (fail_req ? SLW_FAIL : SLW_NORMAL);
      SLW_FAIL:   mode_nxt = !wake_in ? SLW_SLEEP : (fail_req ? SLW_FAIL : SLW_NORMAL);
      default:    mode_nxt = SLW_OFF;
    endcase
    if (power_off) begin
      mode_nxt = SLW_OFF;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_r <= SLW_OFF;
    end else if (ce_in) begin
      mode_r <= mode_nxt;
    end
  end
  assign mode_out = mode_r;

  // logic supply gone with battery present: watchdog is forced to expire
  assign wd_expire_out = vlog_loss_only;

  // free running pwm counter
  logic [PWM_W-1:0] pwm_cnt_r;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwm_cnt_r <= '0;
    end else if (ce_in) begin
      pwm_cnt_r <= pwm_cnt_r + PWM_W'(1);
    end
  end

  // channel drive selection
  logic [NUM_CH-1:0] pwm_drive;
  logic [NUM_CH-1:0] dir_drive;
  logic [NUM_CH-1:0] ch_nxt;
  logic              ch_kill;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      pwm_drive[i] = ch_en_r[i] && (pwm_cnt_r < duty_r[i]);
    end
  end
  // direct inputs; the fifth channel has no direct input
  assign dir_drive = {1'b0, dir_s};
  // channels off on battery or ground loss
  assign ch_kill = power_off || !bat_ok || gnd_lost;
  assign ch_nxt  = ch_kill ? CH_OFF :
                   (mode_r == SLW_NORMAL) ? pwm_drive :
                   (mode_r == SLW_FAIL)   ? dir_drive : CH_OFF;

  // channels cut combinationally from the synchronised levels, bypassing the channel register
  logic [NUM_CH-1:0] ch_r;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ch_r <= CH_OFF;
    end else if (ce_in) begin
      ch_r <= ch_nxt;
    end
  end
  assign power_channels = ch_kill ? CH_OFF : ch_r;

  // external switch follows configuration while logic supply holds
  // ground lost: released so the pull-up wins
  logic ext_r;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_r <= 1'b0;
    end else if (ce_in) begin
      ext_r <= ext_sw_r && vlog_ok && !gnd_lost;
    end
  end
  assign external_switch_output = ext_r;
  assign external_switch_oe_out = vlog_ok && !gnd_lost;

  // read path needs the logic supply
  logic [CFG_W-1:0] rd_data_r;
  logic             rd_valid_r;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
    end else if (ce_in) begin
      rd_valid_r <= rd_req_in && vlog_ok;
      rd_data_r  <= (rd_req_in && vlog_ok) ? fault_r : '0;
    end
  end
  assign rd_data_out  = rd_data_r;
  assign rd_valid_out = rd_valid_r;

  // default sense sync period on pwm clock failure
  logic [SYNC_CNT_W-1:0] sync_cnt_r;
  logic                  sync_pulse_r;
  localparam logic [SYNC_CNT_W-1:0] SYNC_LAST = SYNC_CNT_W'(SYNC_PERIOD_CYC - 1);
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_cnt_r   <= '0;
      sync_pulse_r <= 1'b0;
    end else if (ce_in) begin
      if (!pwm_clk_fail_in || sync_cnt_r == SYNC_LAST) begin
        sync_cnt_r <= '0;
      end else begin
        sync_cnt_r <= sync_cnt_r + SYNC_CNT_W'(1);
      end
      sync_pulse_r <= pwm_clk_fail_in && (sync_cnt_r == SYNC_LAST);
    end
  end
  assign sense_sync_output = sync_pulse_r;

  logic report_r;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      report_r <= 1'b0;
    end else if (ce_in) begin
      report_r <= !host_rst && wake_in && !woke_by_reset_in && bat_ok
                  && mode_r != SLW_OFF;
    end
  end
  assign clk_pin_out        = report_r;
  assign clk_pin_oe_out     = report_r;
  assign clk_pin_sample_out = clk_pin_s;
endmodule

// ===== hw/slw_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for a vector of asynchronous levels
module slw_sync
  import slw_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk_in,  // system clock
  input  wire logic         nrst_in,  // async reset, active low
  input  wire logic         ce_in,    // clock enable
  input  wire logic [W-1:0] d_in,     // asynchronous levels
  output logic      [W-1:0] q_out     // synchronised levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage is read by the second stage only
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= '0;
      q_r    <= '0;
    end else if (ce_in) begin
      meta_r <= d_in;
      q_r    <= meta_r;
    end
  end

  assign q_out = q_r;
endmodule

// ===== pkg/slw_pkg.sv
package slw_pkg;
  // channel, fault and stage counts, configuration width
  localparam int unsigned NUM_CH     = 5;
  localparam int unsigned NUM_DIR    = 4;
  localparam int unsigned NUM_FAULT  = 8;
  localparam int unsigned CFG_W      = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // fault flag positions
  localparam int unsigned FLT_OPEN   = 0;
  localparam int unsigned FLT_SHORT_SUP = 1;
  localparam int unsigned FLT_SEV_GND = 2;
  localparam int unsigned FLT_OVC    = 3;
  localparam int unsigned FLT_OVT    = 4;
  localparam int unsigned FLT_CLK    = 5;
  localparam int unsigned FLT_UV     = 6;
  localparam int unsigned FLT_OV     = 7;

  // reset values
  localparam logic [CFG_W-1:0]     CFG_RST   = 8'h00;
  localparam logic [NUM_FAULT-1:0] FAULT_RST = 8'h00;
  localparam logic [NUM_CH-1:0]    CH_OFF    = 5'h00;

  // timing: clock 125 MHz
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned SYNC_PERIOD_US  = 6500;   // nominal sense sync period
  localparam int unsigned SYNC_MIN_US     = 4800;
  localparam int unsigned SYNC_MAX_US     = 8200;
  localparam int unsigned SYNC_PERIOD_CYC = SYNC_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SYNC_CNT_W      = 20;

  // pwm counter
  localparam int unsigned PWM_W = 8;

  typedef enum logic [1:0] {
    SLW_OFF,
    SLW_SLEEP,
    SLW_NORMAL,
    SLW_FAIL
  } slw_mode_t;
endpackage

// ===== testbench/slw_ctrl_monitor.sv
`timescale 1ns/10ps
// watches the supply, pin and mode ports of the controller
module slw_ctrl_chk
  import slw_pkg::*;
(
  input wire logic                 mclk_in,                // clock
  input wire logic                 nrst_in,                // reset
  input wire logic                 ce_in,                  // enable
  input wire logic                 wake_in,                // wake
  input wire logic                 host_reset_in,          // host reset
  input wire logic                 woke_by_reset_in,       // wake source
  input wire logic                 bat_por_ok_in,          // battery ok
  input wire logic                 vlog_por_ok_in,         // logic ok
  input wire logic                 gnd_lost_in,            // ground lost
  input wire logic                 fail_mode_in,           // fail pin
  input wire logic                 rd_req_in,              // read request
  input wire logic                 pwm_clk_fail_in,        // pwm clock failure
  input wire logic                 clk_pin_out,            // pin level
  input wire logic                 clk_pin_oe_out,         // pin enable
  input wire logic [NUM_CH-1:0]    power_channels,         // channels
  input wire logic                 external_switch_oe_out, // switch enable
  input wire logic [NUM_FAULT-1:0] fault_out,              // faults
  input wire logic [CFG_W-1:0]     rd_data_out,            // read data
  input wire logic                 rd_valid_out,           // read valid
  input wire logic                 sense_sync_output,      // sync pulse
  input wire logic [1:0]           mode_out,               // mode
  input wire logic                 wd_expire_out           // watchdog
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // windows are long enough for the two-flop synchroniser plus one register
  wire sup_ok = ce_in && bat_por_ok_in && vlog_por_ok_in && !gnd_lost_in;
  // cycles spent in clock failure; a counter, since the period is far beyond any repetition
  localparam int unsigned SYNC_MIN_CYC = SYNC_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SYNC_MAX_CYC = SYNC_MAX_US * (CLK_HZ / 1_000_000);
  logic [20:0] fail_cyc_r;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fail_cyc_r <= 21'h000000;
    end else if (!pwm_clk_fail_in) begin
      fail_cyc_r <= 21'h000000;
    end else if (ce_in && fail_cyc_r != 21'h1fffff) begin
      fail_cyc_r <= fail_cyc_r + 21'h000001;
    end
  end
  sequence s_report;
    (sup_ok && wake_in && !host_reset_in && !woke_by_reset_in) [*6];
  endsequence
  sequence s_bat_lost;
    (!bat_por_ok_in && vlog_por_ok_in && ce_in) [*4];
  endsequence
  sequence s_vlog_lost;
    (bat_por_ok_in && !vlog_por_ok_in && ce_in) [*4];
  endsequence
  chk_report_awake: assert property (s_report |-> clk_pin_oe_out && clk_pin_out)
    else $error("clock pin not reporting awake");
  chk_report_only_low: assert property (host_reset_in [*4] |-> !clk_pin_oe_out)
    else $error("clock pin driven with host reset high");
  chk_pin_input: assert property ((!wake_in || woke_by_reset_in) [*4] |-> !clk_pin_oe_out)
    else $error("clock pin driven in sleep");
  chk_power_off: assert property ((!bat_por_ok_in && !vlog_por_ok_in) [*4] |->
    power_channels == CH_OFF && fault_out == FAULT_RST && mode_out == SLW_OFF)
    else $error("power off state wrong");
  chk_bat_lost: assert property (s_bat_lost |-> power_channels == CH_OFF && !clk_pin_oe_out)
    else $error("battery loss handling wrong");
  chk_read_refused: assert property (s_vlog_lost ##0 rd_req_in |=> !rd_valid_out)
    else $error("read answered without logic supply");
  chk_read_answer: assert property
    ((ce_in && bat_por_ok_in && vlog_por_ok_in) [*4] ##0 rd_req_in |=> rd_valid_out)
    else $error("read not answered");
  chk_read_data: assert property (rd_valid_out |-> rd_data_out == $past(fault_out))
    else $error("read data differs from fault flags");
  chk_wd_expire: assert property (s_vlog_lost |-> wd_expire_out && mode_out == SLW_FAIL)
    else $error("logic supply loss did not expire watchdog");
  chk_gnd_off: assert property (gnd_lost_in [*4] |->
    power_channels == CH_OFF && !external_switch_oe_out)
    else $error("ground loss handling wrong");
  chk_fail_input: assert property ((sup_ok && wake_in && fail_mode_in) [*6] |-> mode_out == SLW_FAIL)
    else $error("fail input ignored");
  chk_sync_single: assert property (sense_sync_output |=> !sense_sync_output)
    else $error("sync pulse too long");
  chk_sync_idle: assert property (ce_in && !pwm_clk_fail_in |=> !sense_sync_output)
    else $error("sync pulse without clock failure");
  chk_sync_period: assert property (sense_sync_output |->
    fail_cyc_r >= 21'(SYNC_MIN_CYC) && fail_cyc_r <= 21'(SYNC_MAX_CYC))
    else $error("sync period outside its bounds");
endmodule
bind slw_ctrl slw_ctrl_chk u_slw_ctrl_chk (.mclk_in, .nrst_in, .ce_in, .wake_in, .host_reset_in,
  .woke_by_reset_in, .bat_por_ok_in, .vlog_por_ok_in, .gnd_lost_in, .fail_mode_in, .rd_req_in,
  .pwm_clk_fail_in,
  .clk_pin_out, .clk_pin_oe_out, .power_channels, .external_switch_oe_out, .fault_out,
  .rd_data_out, .rd_valid_out, .sense_sync_output, .mode_out, .wd_expire_out);

// ===== testbench/slw_host_model.sv
`timescale 1ns/10ps
// host side of the shared clock pin
module slw_host_model (
  input  wire logic mclk_in,    // clock
  input  wire logic nrst_in,    // reset
  input  wire logic pin_out_in, // device pin level
  input  wire logic pin_oe_in,  // device drives pin
  output logic      pin_in_out  // resolved pin
);
  logic tgl_r;
  // host clocks the pin when released, so a stale level never passes for a report
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) tgl_r <= 1'b0;
    else tgl_r <= ~tgl_r;
  end
  assign pin_in_out = pin_oe_in ? pin_out_in : tgl_r;
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import slw_pkg::*;
  logic mclk_in = 0, nrst_in = 0, ce_in = 1, wake_in = 1, host_reset_in = 1;
  logic woke_by_reset_in = 0, bat_por_ok_in = 1, vlog_por_ok_in = 1, gnd_lost_in = 0;
  logic fail_mode_in = 0, spi_err_in = 0, spi_wd_timeout_in = 0, cfg_we_in = 0;
  logic rd_req_in = 0, fault_clr_in = 0, pwm_clk_fail_in = 0;
  logic [NUM_DIR-1:0]   direct_in    = 4'h0;
  logic [2:0]           cfg_sel_in   = 3'h0;
  logic [CFG_W-1:0]     cfg_wdata_in = 8'h00;
  logic [NUM_FAULT-1:0] fault_set_in = 8'h00;
  logic [NUM_FAULT-1:0] fault_out;
  logic [CFG_W-1:0]     rd_data_out;
  logic [NUM_CH-1:0]    power_channels;
  logic [1:0]           mode_out;
  logic clk_pin_in, clk_pin_out, clk_pin_oe_out, external_switch_output, external_switch_oe_out;
  logic rd_valid_out, sense_sync_output, wd_expire_out, clk_pin_sample_out;
  int n_fail = 0;
  int n_checks = 0;
  always #4 mclk_in = ~mclk_in;
  slw_ctrl u_slw_ctrl (.mclk_in, .nrst_in, .ce_in, .wake_in, .host_reset_in, .woke_by_reset_in,
    .bat_por_ok_in, .vlog_por_ok_in, .gnd_lost_in, .fail_mode_in, .direct_in, .spi_err_in,
    .spi_wd_timeout_in, .cfg_we_in, .cfg_sel_in, .cfg_wdata_in, .rd_req_in, .fault_set_in,
    .fault_clr_in, .pwm_clk_fail_in, .clk_pin_in, .clk_pin_out, .clk_pin_oe_out,
    .power_channels, .external_switch_output, .external_switch_oe_out, .fault_out,
    .rd_data_out, .rd_valid_out, .sense_sync_output, .mode_out, .wd_expire_out,
    .clk_pin_sample_out);
  slw_host_model u_slw_host_model (.mclk_in, .nrst_in, .pin_out_in(clk_pin_out),
    .pin_oe_in(clk_pin_oe_out), .pin_in_out(clk_pin_in));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one-cycle write strobe, then a quiet edge before the next request
  task automatic cfg_write(input logic [2:0] sel, input logic [7:0] d);
    cfg_we_in <= 1'b1;
    cfg_sel_in <= sel;
    cfg_wdata_in <= d;
    tick(1);
    cfg_we_in <= 1'b0;
    tick(1);
  endtask
  // answer lands one cycle after the request edge and stands one cycle
  task automatic rd_expect(input logic valid, input logic [7:0] d);
    rd_req_in <= 1'b1;
    tick(1);
    rd_req_in <= 1'b0;
    #1;
    check(rd_valid_out, valid);
    if (valid) check(rd_data_out, d);
    tick(1);
  endtask
  // pwm turns channel 0 on within one period; bounded so a dead pwm cannot hang
  task automatic pwm_on;
    int i;
    cfg_write(3'h6, 8'h1f);
    cfg_write(3'h0, 8'hff);
    for (i = 0; i < 600 && power_channels[0] !== 1'b1; i++) tick(1);
    check(power_channels[0], 8'h01);
    cfg_write(3'h5, 8'h01);
    tick(2);
  endtask
  initial begin
    tick(20000);
    n_fail++;
    conclude;
  end
  initial begin
    tick(10);
    nrst_in <= 1'b1;
    tick(8);
    check(mode_out, SLW_NORMAL);
    wake_in <= 1'b0;
    tick(5);
    check(mode_out, SLW_SLEEP);
    wake_in <= 1'b1;
    host_reset_in <= 1'b0;
    tick(8);
    check(clk_pin_oe_out, 8'h01);
    check(clk_pin_sample_out, 8'h01);
    woke_by_reset_in <= 1'b1;
    tick(5);
    check(clk_pin_oe_out, 8'h00);
    woke_by_reset_in <= 1'b0;
    tick(6);
    host_reset_in <= 1'b1;
    tick(5);
    check(clk_pin_oe_out, 8'h00);
    // every fault kind is flagged and read back
    for (int i = 0; i < NUM_FAULT; i++) begin
      fault_set_in <= 8'h01 << i;
      tick(1);
      fault_set_in <= 8'h00;
      tick(1);
      rd_expect(1'b1, (8'h02 << i) - 8'h01);
    end
    fault_clr_in <= 1'b1;
    fault_set_in <= 8'h10;
    tick(1);
    fault_clr_in <= 1'b0;
    fault_set_in <= 8'h00;
    tick(1);
    check(fault_out, 8'h10);
    pwm_on;
    check(external_switch_output, 8'h01);
    bat_por_ok_in <= 1'b0;
    host_reset_in <= 1'b0;
    tick(6);
    check(power_channels, 8'h00);
    check(external_switch_output, 8'h01);
    check(clk_pin_oe_out, 8'h00);
    rd_expect(1'b1, 8'h10);
    bat_por_ok_in <= 1'b1;
    host_reset_in <= 1'b1;
    tick(5);
    vlog_por_ok_in <= 1'b0;
    tick(5);
    check(wd_expire_out, 8'h01);
    check(mode_out, SLW_FAIL);
    rd_expect(1'b0, 8'h00);
    bat_por_ok_in <= 1'b0;
    tick(5);
    check(mode_out, SLW_OFF);
    check(fault_out, 8'h00);
    bat_por_ok_in <= 1'b1;
    vlog_por_ok_in <= 1'b1;
    tick(8);
    check(external_switch_output, 8'h00);
    rd_expect(1'b1, 8'h00);
    pwm_on;
    gnd_lost_in <= 1'b1;
    tick(5);
    check(power_channels, 8'h00);
    check(external_switch_oe_out, 8'h00);
    gnd_lost_in <= 1'b0;
    fail_mode_in <= 1'b1;
    direct_in <= 4'ha;
    tick(6);
    check(mode_out, SLW_FAIL);
    check(power_channels, 8'h0a);
    fail_mode_in <= 1'b0;
    tick(6);
    spi_err_in <= 1'b1;
    tick(3);
    check(mode_out, SLW_FAIL);
    spi_err_in <= 1'b0;
    tick(2);
    // back to normal first, so the timeout alone must bring fail mode
    check(mode_out, SLW_NORMAL);
    spi_wd_timeout_in <= 1'b1;
    tick(3);
    check(mode_out, SLW_FAIL);
    spi_wd_timeout_in <= 1'b0;
    tick(2);
    // clock failure flags a fault and must not fire the sync pulse early
    pwm_clk_fail_in <= 1'b1;
    tick(3);
    check(fault_out, 8'h20);
    check(sense_sync_output, 8'h00);
    // enable low freezes the flags although an event is offered
    ce_in <= 1'b0;
    fault_set_in <= 8'h01;
    tick(2);
    check(fault_out, 8'h20);
    ce_in <= 1'b1;
    fault_set_in <= 8'h00;
    pwm_clk_fail_in <= 1'b0;
    tick(2);
    conclude;
  end
endmodule
